// ### inc/pwm_pkg.sv
package pwm_pkg;

    // ************************************************************
    // waveform geometry
    // ************************************************************
    localparam int SUBSEC_BITS = 4;
    localparam int STEP_BITS = 8;
    localparam int LEVEL_BITS = SUBSEC_BITS + STEP_BITS;
    localparam int CHANNELS = 4;
    localparam int CHAN_BITS = 2;
    // one step is two reference clock periods
    localparam int STEP_CLOCKS = 2;
    localparam logic [SUBSEC_BITS-1:0] LAST_SUBSEC = 4'hf;
    localparam logic [STEP_BITS-1:0] LAST_STEP = 8'hff;

    // ************************************************************
    // rate multiplier subsection patterns
    // ************************************************************
    localparam logic [3:0] RM_EIGHT = 4'h8;
    localparam logic [2:0] RM_FOUR = 3'h4;
    localparam logic [1:0] RM_TWO = 2'h2;
    localparam int NIB_ODD = 3;
    localparam int NIB_TWO = 2;
    localparam int NIB_FOUR = 1;
    localparam int NIB_EIGHT = 0;

    // ************************************************************
    // command low byte layout
    // ************************************************************
    localparam int NIBBLE_MSB = 7;
    localparam int NIBBLE_LSB = 4;
    localparam int OUTPUT_SELECT_BIT = 3;
    localparam int CHANNEL_SEL_HI = 2;
    localparam int CHANNEL_SEL_LO = 1;
    localparam int UPPER_FOLLOWS_BIT = 0;
    localparam logic [7:0] HOLD_RESET = 8'h00;
    localparam logic [LEVEL_BITS-1:0] LEVEL_RESET = 12'h000;

    // ************************************************************
    // types
    // ************************************************************
    typedef struct packed {
        logic enable;
        logic [LEVEL_BITS-1:0] level;
    } chan_setting_type;

    typedef struct packed {
        logic cs_n;
        logic wr_n;
        logic sclk;
        logic serial_in;
        logic output_float_ctrl;
        logic clear_req_n;
    } pin_type;

    localparam pin_type PIN_IDLE = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};

    typedef enum logic [1:0] {
        BYTE_LOW = 2'b01,
        BYTE_HIGH = 2'b10
    } byte_state_type;

    typedef enum logic [1:0] {
        CORE_RUN = 2'b01,
        CORE_HELD = 2'b10
    } core_state_type;

endpackage

// ### rtl/pwm_channel.sv
`timescale 1ns/1ps
module pwm_channel (
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // timing from the shared counter
    input wire logic step_tick,
    input wire logic cycle_start,
    input wire logic wipe,
    input wire logic next_float,
    input wire logic [pwm_pkg::SUBSEC_BITS-1:0] next_subsec,
    input wire logic [pwm_pkg::STEP_BITS-1:0] next_step,
    // setting waiting for the next cycle
    input wire pwm_pkg::chan_setting_type pending,
    // pin drive
    output logic pulse,
    output logic drive
);

    pwm_pkg::chan_setting_type active;
    pwm_pkg::chan_setting_type next_active;
    logic [3:0] nib;
    logic lengthen;
    logic [pwm_pkg::STEP_BITS:0] width;
    logic next_high;

    // new value only at cycle start, never mid-waveform
    assign next_active = cycle_start ? pending : active;
    assign nib = next_active.level[pwm_pkg::SUBSEC_BITS-1:0];

    // bit-reversed rate multiplier; subsection 0 matches no term
    assign lengthen = (next_subsec[0] & nib[pwm_pkg::NIB_ODD])
        | ((next_subsec[1:0] == pwm_pkg::RM_TWO) & nib[pwm_pkg::NIB_TWO])
        | ((next_subsec[2:0] == pwm_pkg::RM_FOUR) & nib[pwm_pkg::NIB_FOUR])
        | ((next_subsec == pwm_pkg::RM_EIGHT) & nib[pwm_pkg::NIB_EIGHT]);

    // upper eight bits give the basic width of every subsection
    assign width = {1'b0, next_active.level[pwm_pkg::LEVEL_BITS-1:pwm_pkg::SUBSEC_BITS]}
        + {{pwm_pkg::STEP_BITS{1'b0}}, lengthen};

    // at most 255 steps in subsection 0, so a full high cycle is impossible
    assign next_high = {1'b0, next_step} < width;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            active <= '0;
        end else if (wipe) begin
            active <= '0;
        end else if (step_tick) begin
            active <= next_active;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pulse <= 1'b0;
            drive <= 1'b0;
        end else if (wipe) begin
            pulse <= 1'b0;
            drive <= 1'b0;
        end else if (step_tick) begin
            pulse <= next_high;
            drive <= next_active.enable & ~next_float;
        end
    end

endmodule

// ### rtl/quad_pwm_top.sv
`timescale 1ns/1ps
module quad_pwm_top (
    // clock and power-on reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // serial write port
    input wire logic cs_n,
    input wire logic wr_n,
    input wire logic sclk,
    input wire logic serial_in,
    // global controls
    input wire logic output_float_ctrl,
    input wire logic clear_req_n,
    // pulse outputs, three-state
    output logic [pwm_pkg::CHANNELS-1:0] pulse_out_1_to_4,
    output logic [pwm_pkg::CHANNELS-1:0] pulse_oe
);

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    pwm_pkg::pin_type pins_raw;
    pwm_pkg::pin_type pins_meta;
    pwm_pkg::pin_type pins_sync;
    pwm_pkg::pin_type pins_last;

    assign pins_raw = '{cs_n, wr_n, sclk, serial_in, output_float_ctrl, clear_req_n};

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pins_meta <= pwm_pkg::PIN_IDLE;
            pins_sync <= pwm_pkg::PIN_IDLE;
            pins_last <= pwm_pkg::PIN_IDLE;
        end else begin
            pins_meta <= pins_raw;
            pins_sync <= pins_meta;
            pins_last <= pins_sync;
        end
    end

    wire sclk_rise;
    wire wr_rise;
    wire port_open;

    assign port_open = ~pins_sync.cs_n;
    assign sclk_rise = pins_sync.sclk & ~pins_last.sclk;
    assign wr_rise = pins_sync.wr_n & ~pins_last.wr_n;

    // ************************************************************
    // step divider and cycle position
    // ************************************************************
    logic step_phase;
    logic [pwm_pkg::SUBSEC_BITS-1:0] subsec;
    logic [pwm_pkg::STEP_BITS-1:0] step;
    pwm_pkg::core_state_type core_state;
    pwm_pkg::core_state_type next_core_state;
    logic float_cycle;

    wire step_tick;
    wire at_cycle_end;
    wire cycle_start;
    wire wipe;
    wire next_float;
    wire [pwm_pkg::SUBSEC_BITS-1:0] next_subsec;
    wire [pwm_pkg::STEP_BITS-1:0] next_step;
    wire core_held;

    // timing clock is the reference clock halved
    assign step_tick = step_phase;
    assign core_held = (core_state == pwm_pkg::CORE_HELD);
    assign at_cycle_end = (subsec == pwm_pkg::LAST_SUBSEC) && (step == pwm_pkg::LAST_STEP);

    // clear is only honoured at the end of a running cycle
    assign wipe = step_tick && at_cycle_end && !core_held
        && !pins_sync.clear_req_n;
    // a held core restarts at the next tick once clear is released
    assign cycle_start = step_tick && at_cycle_end && pins_sync.clear_req_n;
    assign next_step = cycle_start ? '0 : step + 8'h01;
    assign next_subsec = cycle_start ? '0
        : (step == pwm_pkg::LAST_STEP) ? subsec + 4'h1 : subsec;
    // float decision fixed for the whole cycle
    assign next_float = cycle_start ? pins_sync.output_float_ctrl : float_cycle;

    always_comb begin
        next_core_state = core_state;
        case (core_state)
            pwm_pkg::CORE_RUN: begin
                if (wipe) begin
                    next_core_state = pwm_pkg::CORE_HELD;
                end
            end
            pwm_pkg::CORE_HELD: begin
                if (cycle_start) begin
                    next_core_state = pwm_pkg::CORE_RUN;
                end
            end
            default: begin
                next_core_state = pwm_pkg::CORE_HELD;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            step_phase <= 1'b0;
        end else begin
            step_phase <= ~step_phase;
        end
    end

    // position parks on the last step while held, so release wraps to 0
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            subsec <= pwm_pkg::LAST_SUBSEC;
            step <= pwm_pkg::LAST_STEP;
        end else if (step_tick && !core_held && !wipe) begin
            subsec <= next_subsec;
            step <= next_step;
        end else if (step_tick && cycle_start) begin
            subsec <= next_subsec;
            step <= next_step;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            core_state <= pwm_pkg::CORE_HELD;
            float_cycle <= 1'b1;
        end else begin
            core_state <= next_core_state;
            if (step_tick) begin
                float_cycle <= next_float;
            end
        end
    end

    // ************************************************************
    // serial shifter
    // ************************************************************
    logic [7:0] shifter;

    wire shift_now;

    assign shift_now = sclk_rise && port_open && !pins_sync.wr_n;

    // msb first: the eighth bit lands in bit 0
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            shifter <= pwm_pkg::HOLD_RESET;
        end else if (shift_now) begin
            shifter <= {shifter[6:0], pins_sync.serial_in};
        end
    end

    // ************************************************************
    // byte holding registers
    // ************************************************************
    logic [7:0] command_low_byte_hold;
    logic [7:0] data_high_byte_hold;
    pwm_pkg::byte_state_type byte_state;
    pwm_pkg::byte_state_type next_byte_state;

    wire byte_done;
    wire take_low;
    wire take_high;
    wire output_select_bit;
    wire upper_follows_bit;
    wire [pwm_pkg::CHAN_BITS-1:0] chan_sel;
    wire [3:0] nibble;
    wire load_nibble;
    wire load_disable;

    // writes are refused while the core is wiped and held
    assign byte_done = wr_rise && port_open && !core_held;
    assign take_low = byte_done && (byte_state == pwm_pkg::BYTE_LOW);
    assign take_high = byte_done && (byte_state == pwm_pkg::BYTE_HIGH);

    assign output_select_bit = shifter[pwm_pkg::OUTPUT_SELECT_BIT];
    assign upper_follows_bit = shifter[pwm_pkg::UPPER_FOLLOWS_BIT];
    // low nibble only is loaded when no upper byte is announced
    assign load_nibble = take_low && output_select_bit && !upper_follows_bit;
    assign load_disable = take_low && !output_select_bit;

    assign chan_sel = {command_low_byte_hold[pwm_pkg::CHANNEL_SEL_HI],
        command_low_byte_hold[pwm_pkg::CHANNEL_SEL_LO]};
    assign nibble = command_low_byte_hold[pwm_pkg::NIBBLE_MSB:pwm_pkg::NIBBLE_LSB];

    always_comb begin
        next_byte_state = byte_state;
        case (byte_state)
            pwm_pkg::BYTE_LOW: begin
                if (take_low && output_select_bit && upper_follows_bit) begin
                    next_byte_state = pwm_pkg::BYTE_HIGH;
                end
            end
            pwm_pkg::BYTE_HIGH: begin
                if (take_high) begin
                    next_byte_state = pwm_pkg::BYTE_LOW;
                end
            end
            default: begin
                next_byte_state = pwm_pkg::BYTE_LOW;
            end
        endcase
    end

    // power-on reset settles the held upper-follows bit, so a dummy byte is harmless
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            byte_state <= pwm_pkg::BYTE_LOW;
            command_low_byte_hold <= pwm_pkg::HOLD_RESET;
            data_high_byte_hold <= pwm_pkg::HOLD_RESET;
        end else if (wipe) begin
            byte_state <= pwm_pkg::BYTE_LOW;
            command_low_byte_hold <= pwm_pkg::HOLD_RESET;
            data_high_byte_hold <= pwm_pkg::HOLD_RESET;
        end else begin
            byte_state <= next_byte_state;
            if (take_low) begin
                command_low_byte_hold <= output_select_bit ? shifter
                    : {shifter[7:1], 1'b0};
            end
            if (take_high) begin
                data_high_byte_hold <= shifter;
            end
        end
    end

    // a single-byte commit acts on the byte just shifted, not the old hold
    wire [pwm_pkg::CHAN_BITS-1:0] low_chan_sel;
    wire [3:0] low_nibble;
    wire [pwm_pkg::CHAN_BITS-1:0] commit_chan;

    assign low_chan_sel = {shifter[pwm_pkg::CHANNEL_SEL_HI], shifter[pwm_pkg::CHANNEL_SEL_LO]};
    assign low_nibble = shifter[pwm_pkg::NIBBLE_MSB:pwm_pkg::NIBBLE_LSB];
    assign commit_chan = take_high ? chan_sel : low_chan_sel;

    // ************************************************************
    // pending settings and channels
    // ************************************************************
    pwm_pkg::chan_setting_type pending [pwm_pkg::CHANNELS];
    logic [pwm_pkg::CHANNELS-1:0] lane_pulse;
    logic [pwm_pkg::CHANNELS-1:0] lane_drive;

    genvar ch;
    generate
        for (ch = 0; ch < pwm_pkg::CHANNELS; ch = ch + 1) begin : g_chan
            wire hit;

            assign hit = (commit_chan == pwm_pkg::CHAN_BITS'(ch));

            // kept and still writable while outputs float
            always_ff @(posedge ref_clk or negedge arst_n) begin
                if (!arst_n) begin
                    pending[ch] <= '0;
                end else if (wipe) begin
                    pending[ch] <= '0;
                end else if (hit && take_high) begin
                    pending[ch].enable <= 1'b1;
                    pending[ch].level <= {shifter, nibble};
                end else if (hit && load_nibble) begin
                    pending[ch].enable <= 1'b1;
                    pending[ch].level[pwm_pkg::SUBSEC_BITS-1:0] <= low_nibble;
                end else if (hit && load_disable) begin
                    pending[ch].enable <= 1'b0;
                end
            end

            pwm_channel u_channel (
                .ref_clk(ref_clk),
                .arst_n(arst_n),
                .step_tick(step_tick),
                .cycle_start(cycle_start),
                .wipe(wipe),
                .next_float(next_float),
                .next_subsec(next_subsec),
                .next_step(next_step),
                .pending(pending[ch]),
                .pulse(lane_pulse[ch]),
                .drive(lane_drive[ch])
            );
        end
    endgenerate

    // ************************************************************
    // outputs
    // ************************************************************
    assign pulse_out_1_to_4 = lane_pulse;
    assign pulse_oe = lane_drive;

endmodule

// ### verif/quad_pwm_chk.sv
`timescale 1ns/1ps
module quad_pwm_chk (
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // serial port
    input wire logic cs_n,
    input wire logic wr_n,
    input wire logic sclk,
    input wire logic serial_in,
    // global controls
    input wire logic output_float_ctrl,
    input wire logic clear_req_n,
    // pulse outputs
    input wire logic [pwm_pkg::CHANNELS-1:0] pulse_out_1_to_4,
    input wire logic [pwm_pkg::CHANNELS-1:0] pulse_oe
);
    // ********************
    // helper counters
    // ********************
    logic [13:0] clr_cnt;
    logic [13:0] flt_cnt;
    logic [13:0] hi_len;
    // 17-bit gaps wrap on a multiple of a full cycle, so no saturation needed
    logic [16:0] oe_gap;
    logic [16:0] rise_gap;
    logic [3:0] oe_prev;
    logic wr_prev;
    logic wrote;
    logic oe_seen;
    logic rise_seen;
    logic p0_prev;
    wire logic oe_chg = pulse_oe != oe_prev;
    wire logic p0 = pulse_out_1_to_4[0] & pulse_oe[0];
    wire logic p0_rise = p0 & !p0_prev;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            clr_cnt <= 14'h0000;
            flt_cnt <= 14'h0000;
            hi_len <= 14'h0000;
            oe_gap <= 17'h0_0000;
            rise_gap <= 17'h0_0000;
            oe_prev <= 4'h0;
            wr_prev <= 1'b1;
            wrote <= 1'b0;
            oe_seen <= 1'b0;
            rise_seen <= 1'b0;
            p0_prev <= 1'b0;
        end else begin
            clr_cnt <= clear_req_n ? 14'h0000 : clr_cnt + 14'(clr_cnt != 14'h3fff);
            flt_cnt <= !output_float_ctrl ? 14'h0000 : flt_cnt + 14'(flt_cnt != 14'h3fff);
            hi_len <= p0 ? hi_len + 14'(hi_len != 14'h3fff) : 14'h0000;
            oe_prev <= pulse_oe;
            oe_gap <= oe_chg ? 17'h0_0001 : oe_gap + 17'h0_0001;
            oe_seen <= clear_req_n & (oe_seen | oe_chg);
            p0_prev <= p0;
            rise_gap <= p0_rise ? 17'h0_0001 : rise_gap + 17'h0_0001;
            rise_seen <= clear_req_n & pulse_oe[0] & (rise_seen | p0_rise);
            wr_prev <= wr_n;
            wrote <= (clr_cnt <= 14'h2010) & (wrote | (wr_n & !wr_prev & !cs_n));
        end
    end

    // ********************
    // properties
    // ********************
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);

    sequence s_rise_again;
        rise_seen && p0 && !p0_prev;
    endsequence
    sequence s_fall_driven;
        p0_prev && !pulse_out_1_to_4[0] && pulse_oe[0];
    endsequence

    AST_FLOAT_ALL: assert property (flt_cnt > 14'h2010 |-> pulse_oe == 4'h0)
        else $error("outputs driven during a long float request");
    AST_OE_NOT_FLOATED: assert property ($rose(pulse_oe[0]) |-> flt_cnt < 14'h0008)
        else $error("output enabled although float was requested");
    AST_CLEAR_FLOATS: assert property (clr_cnt > 14'h2010 |-> pulse_oe == 4'h0)
        else $error("outputs driven after a long clear request");
    AST_OE_NEEDS_WRITE: assert property (pulse_oe != 4'h0 |-> wrote)
        else $error("output enabled without an enabling write");
    AST_OE_AT_CYCLE: assert property (oe_chg && oe_seen |-> oe_gap[12:0] == 13'h0000)
        else $error("output enable changed inside a cycle");
    AST_SUBSEC_PERIOD: assert property (s_rise_again |-> rise_gap[8:0] == 9'h000)
        else $error("pulse start off the subsection grid");
    AST_WIDTH_EVEN: assert property (s_fall_driven |-> !hi_len[0] && hi_len != 14'h0000)
        else $error("high time not a whole number of steps");
    AST_NEVER_WHOLE: assert property (pulse_oe[0] |-> hi_len < 14'h2000)
        else $error("channel held high for a whole cycle");
endmodule

bind quad_pwm_top quad_pwm_chk u_chk (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .cs_n(cs_n),
    .wr_n(wr_n),
    .sclk(sclk),
    .serial_in(serial_in),
    .output_float_ctrl(output_float_ctrl),
    .clear_req_n(clear_req_n),
    .pulse_out_1_to_4(pulse_out_1_to_4),
    .pulse_oe(pulse_oe)
);

// ### verif/serial_host.sv
`timescale 1ns/1ps
module serial_host (
    // clock
    input wire logic ref_clk,
    // serial write pins
    output logic cs_n,
    output logic wr_n,
    output logic sclk,
    output logic serial_in
);
    // idle clocks after a byte; raise it to act as a slow host
    int idle = 4;

    initial begin
        cs_n = 1'b1;
        wr_n = 1'b1;
        sclk = 1'b0;
        serial_in = 1'b1;
    end

    task automatic half();
        repeat (4) @(negedge ref_clk);
    endtask

    task automatic send_byte(input logic [7:0] b);
        cs_n = 1'b0;
        half();
        wr_n = 1'b0;
        half();
        for (int i = 7; i >= 0; i--) begin
            serial_in = b[i];
            half();
            sclk = 1'b1;
            half();
            sclk = 1'b0;
            // line no longer valid after hold, so show the inverse
            serial_in = !b[i];
        end
        half();
        wr_n = 1'b1;
        half();
        cs_n = 1'b1;
        repeat (idle) @(negedge ref_clk);
    endtask

    task automatic send_write(input logic [7:0] lo, input logic [7:0] hi, input logic two);
        send_byte(lo);
        if (two && lo[3] && lo[0]) begin
            send_byte(hi);
        end
    endtask
endmodule

// ### verif/tb.sv
`timescale 1ns/1ps
module tb;
    logic ref_clk;
    logic arst_n;
    logic output_float_ctrl;
    logic clear_req_n;
    logic cs_n;
    logic wr_n;
    logic sclk;
    logic serial_in;
    logic [pwm_pkg::CHANNELS-1:0] pulse_out_1_to_4;
    logic [pwm_pkg::CHANNELS-1:0] pulse_oe;
    int failures;
    int tests_run;

    serial_host u_host (
        .ref_clk(ref_clk),
        .cs_n(cs_n),
        .wr_n(wr_n),
        .sclk(sclk),
        .serial_in(serial_in)
    );

    quad_pwm_top dut (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .cs_n(cs_n),
        .wr_n(wr_n),
        .sclk(sclk),
        .serial_in(serial_in),
        .output_float_ctrl(output_float_ctrl),
        .clear_req_n(clear_req_n),
        .pulse_out_1_to_4(pulse_out_1_to_4),
        .pulse_oe(pulse_oe)
    );

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // ********************
    // helpers
    // ********************
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    function automatic logic lengthened(input int m, input logic [3:0] nib);
        return (m % 2 == 1 && nib[3]) || (m % 4 == 2 && nib[2]) ||
            (m % 8 == 4 && nib[1]) || (m == 8 && nib[0]);
    endfunction

    task automatic wait_oe(input int ch);
        int n;
        n = 0;
        while (pulse_oe[ch] !== 1'b1 && n < 9000) begin
            @(negedge ref_clk);
            n++;
        end
        if (n >= 9000) begin
            failures++;
            $display("CHECK FAILED enable wait expected 1 seen timeout");
            end_of_test();
        end
    endtask

    // one full cycle from its start; writes the next low byte meanwhile
    task automatic run_cycle(input logic [3:0] cur, input logic cur_oe, input logic [7:0] lo,
        input logic fl);
        logic [9:0] hi [16];
        logic oe_ok;
        int i;
        fork
            u_host.send_write(lo, 8'h00, 1'b0);
        join_none
        if (fl) output_float_ctrl = 1'b1;
        oe_ok = 1'b1;
        for (i = 0; i < 16; i++) hi[i] = 10'h000;
        for (i = 0; i < 8192; i++) begin
            // late release keeps float clear of the sampling point
            if (i == 400 && !fl) output_float_ctrl = 1'b0;
            hi[i / 512] += 10'(pulse_out_1_to_4[0]);
            if (pulse_oe[0] !== cur_oe || pulse_oe[3:1] !== 3'h0) oe_ok = 1'b0;
            @(negedge ref_clk);
        end
        check("enable held", 16'(oe_ok), 16'h0001);
        for (i = 0; i < 16 && cur_oe; i++) begin
            check("width", 16'(hi[i]), 16'(2 * (8'h4a + lengthened(i, cur))));
        end
        $display("test cycle nibble %h done", cur);
    endtask

    // ********************
    // scenarios
    // ********************
    task automatic test_start();
        repeat (20) @(negedge ref_clk);
        check("enable after reset", 16'(pulse_oe), 16'h0000);
        u_host.send_write(8'h69, 8'h4a, 1'b1);
        wait_oe(0);
        $display("test start done");
    endtask

    task automatic test_rows();
        run_cycle(4'h6, 1'b1, 8'h98, 1'b0);
        run_cycle(4'h9, 1'b1, 8'hf8, 1'b1);
        run_cycle(4'hf, 1'b0, 8'h08, 1'b0);
        run_cycle(4'h0, 1'b1, 8'h01, 1'b0);
    endtask

    task automatic test_clear();
        int i;
        int n1;
        int n0;
        int n3;
        logic [3:0] seen_oe;
        clear_req_n = 1'b0;
        repeat (8) @(negedge ref_clk);
        check("disabled channel", 16'(pulse_oe), 16'h0000);
        repeat (8500) @(negedge ref_clk);
        check("enable in clear", 16'(pulse_oe), 16'h0000);
        clear_req_n = 1'b1;
        seen_oe = 4'h0;
        for (i = 0; i < 8300; i++) begin
            seen_oe |= pulse_oe;
            @(negedge ref_clk);
        end
        check("enable after clear", 16'(seen_oe), 16'h0000);
        u_host.send_write(8'h08, 8'h00, 1'b0);
        u_host.idle = 40;
        u_host.send_write(8'h0b, 8'h10, 1'b1);
        u_host.send_write(8'h0f, 8'h08, 1'b1);
        wait_oe(1);
        n1 = 0;
        n0 = 0;
        n3 = 0;
        for (i = 0; i < 512; i++) begin
            n1 += int'(pulse_out_1_to_4[1] === 1'b1);
            n3 += int'(pulse_out_1_to_4[3] === 1'b1);
            // unknown counts as high so it cannot pass as a zero width
            n0 += int'(pulse_out_1_to_4[0] !== 1'b0);
            @(negedge ref_clk);
        end
        check("enables", 16'(pulse_oe), 16'h000b);
        check("channel 1 width", 16'(n1), 16'h0020);
        check("channel 3 width", 16'(n3), 16'h0010);
        check("wiped channel width", 16'(n0), 16'h0000);
        $display("test clear done");
    endtask

    initial begin
        arst_n = 1'b0;
        output_float_ctrl = 1'b0;
        clear_req_n = 1'b1;
        failures = 0;
        tests_run = 0;
        repeat (16) @(negedge ref_clk);
        arst_n = 1'b1;
        test_start();
        test_rows();
        test_clear();
        end_of_test();
    end
endmodule
